// [sirt_pkg.sv]
/*
  Shared constants for the synchronous DRAM link: command codes, mode word,
  and every timing count but TMRD_CYC derived from the 125 MHz system clock.
  Assumes both ends run on the same clock and sample the link on its rising edge.
*/
`default_nettype none

package sirt_pkg;

  // ------------------------------------------------------------------
  // Link widths and the controller wait counter width
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BANK_W = 2;
  localparam int WAIT_W = 14;

  // ------------------------------------------------------------------
  // Commands as {cs_n, ras_n, cas_n, we_n}
  // ------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;

  // ------------------------------------------------------------------
  // Address fields
  // ------------------------------------------------------------------
  localparam int A_ALLBANK = 10;      // Precharge-all select
  localparam int MODE_CL_LSB = 4;     // Latency field of the mode word
  localparam logic [ADDR_W-1:0] COL_MASK = 12'h5ff; // Column phase drops bits 9 and 11
  localparam logic [ADDR_W-1:0] MODE_VAL = 12'h030; // Latency 3, burst of one
  localparam logic [2:0] CAS_LAT = 3'h3;
  localparam logic [2:0] CAS_LAT_RST = 3'h3;

  // ------------------------------------------------------------------
  // Timing, figures as printed, then cycles at the clock rate
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int PWRUP_TIME_US  = 100;
  localparam int TRP_NS         = 20;  // precharge_period
  localparam int TRCD_NS        = 20;
  localparam int TRFC_NS        = 70;
  localparam int SELF_REFRESH_EXIT_TIME_NS        = 70;  // self_refresh_exit_time
  localparam int TWR_NS         = 12;  // write_recovery_time beyond one clock
  localparam int SLOW_CLK_PS    = 10000;
  localparam int REF_PERIOD_MS  = 64;  // refresh_interval
  localparam int REF_ROWS       = 4096;

  localparam int PWRUP_CYC = (PWRUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRP_CYC   = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRCD_CYC  = (TRCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TRFC_CYC  = (TRFC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SELF_REFRESH_EXIT_TIME_CYC  = (SELF_REFRESH_EXIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMRD_CYC  = 2;
  localparam int TWR_CYC   = (CLK_PERIOD_PS >= SLOW_CLK_PS) ? 1 : 2;
  localparam int REF_ROW_NS = REF_PERIOD_MS * 1000000 / REF_ROWS;
  localparam int REF_CYC    = REF_ROW_NS * 1000 / CLK_PERIOD_PS;

endpackage : sirt_pkg

`default_nettype wire

// [sirt_link_if.sv]
/*
  The memory link between controller end and memory end.
  Assumes both modports sit on one clock; the shared data bus is resolved here
  from each end's output enable (low while that end drives).
*/
`default_nettype none

interface sirt_link_if;

  // ------------------------------------------------------------------
  // Link signals
  // ------------------------------------------------------------------
  logic                          cke;
  logic [3:0]                    cmd;
  logic [sirt_pkg::BANK_W-1:0]   ba;
  logic [sirt_pkg::ADDR_W-1:0]   addr;
  logic [sirt_pkg::DATA_W-1:0]   dq_o_ctl;
  logic                          dq_oe_n_ctl;
  logic [sirt_pkg::DATA_W-1:0]   dq_o_mem;
  logic                          dq_oe_n_mem;
  wire  [sirt_pkg::DATA_W-1:0]   dq;

  // Bus resolution; an idle bus shows the inverse of the last memory word,
  // so a capture taken outside the data slot cannot pass by luck
  assign dq = !dq_oe_n_ctl ? dq_o_ctl : (!dq_oe_n_mem ? dq_o_mem : ~dq_o_mem);

  modport ctl (output cke, output cmd, output ba, output addr,
               output dq_o_ctl, output dq_oe_n_ctl, input dq);
  modport mem (input cke, input cmd, input ba, input addr,
               output dq_o_mem, output dq_oe_n_mem, input dq);

endinterface : sirt_link_if

`default_nettype wire

// [sirt_mem.sv]
/*
  Memory end: a small flip-flop array behind the command decoder, with
  power-down, self refresh and an internal refresh row counter.
  Assumes the controller keeps its own timing; this end only decodes.
*/
`default_nettype none

module sirt_mem (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  sirt_link_if.mem                         link,
  output logic                             init_done,
  output logic                             in_self_refresh,
  output logic                             in_power_down,
  output logic [11:0]                      refresh_row
);

  typedef enum logic [1:0] {SIRT_M_RUN, SIRT_M_PD, SIRT_M_SR} sirt_mstate_t;

  // Command is only valid with clock enable high now and on the prior edge, except self-refresh entry, a refresh with clock enable falling
  function automatic logic sirt_is(input logic [3:0] c, input logic [3:0] k);
    return c == k;
  endfunction : sirt_is

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sirt_mstate_t                 st_r, st_nxt;
  logic                         cke_prev_r;
  logic [1:0]                   wake_cnt_r, wake_cnt_nxt;
  logic [3:0]                   bank_open_r, bank_open_nxt;
  logic [2:0]                   cl_r, cl_nxt;
  logic [11:0]                  row_cnt_r, row_cnt_nxt;
  logic [15:0]                  sr_tmr_r, sr_tmr_nxt;
  logic [2:0]                   rd_cnt_r, rd_cnt_nxt;
  logic [3:0]                   rd_idx_r, rd_idx_nxt;
  logic [sirt_pkg::DATA_W-1:0]  dout_r, dout_nxt;
  logic                         oe_n_r, oe_n_nxt;
  logic [sirt_pkg::DATA_W-1:0]  mem_r [16];
  logic                         wr_en;
  logic [3:0]                   idx;
  logic                         live;
  logic [sirt_pkg::ADDR_W-1:0]  col;

  assign live = cke_prev_r && link.cke && (st_r == SIRT_M_RUN);
  assign col  = link.addr & sirt_pkg::COL_MASK;
  assign idx  = {link.ba, col[1:0]};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    wake_cnt_nxt  = wake_cnt_r;
    bank_open_nxt = bank_open_r;
    cl_nxt        = cl_r;
    row_cnt_nxt   = row_cnt_r;
    sr_tmr_nxt    = sr_tmr_r;
    rd_cnt_nxt    = rd_cnt_r;
    rd_idx_nxt    = rd_idx_r;
    dout_nxt      = dout_r;
    oe_n_nxt      = 1'b1;
    wr_en         = 1'b0;
    // Read data leaves on the edge where the latency count reaches zero
    if (rd_cnt_r != 3'h0) begin
      rd_cnt_nxt = rd_cnt_r - 3'h1;
      if (rd_cnt_r == 3'h1) begin
        dout_nxt = mem_r[rd_idx_r];
        oe_n_nxt = 1'b0;
      end
    end
    case (st_r)
      SIRT_M_RUN: begin
        if (cke_prev_r && !link.cke) begin
          if (sirt_is(link.cmd, sirt_pkg::CMD_REF)) begin
            st_nxt     = SIRT_M_SR;
            sr_tmr_nxt = 16'h0;
          end else if (bank_open_r == 4'h0) begin
            st_nxt = SIRT_M_PD;
          end
        end else if (live) begin
          if (sirt_is(link.cmd, sirt_pkg::CMD_ACT)) begin
            bank_open_nxt[link.ba] = 1'b1;
          end else if (sirt_is(link.cmd, sirt_pkg::CMD_PRE)) begin
            if (link.addr[sirt_pkg::A_ALLBANK]) begin
              bank_open_nxt = 4'h0;
            end else begin
              bank_open_nxt[link.ba] = 1'b0;
            end
            rd_cnt_nxt = 3'h0;
            oe_n_nxt   = 1'b1;
          end else if (sirt_is(link.cmd, sirt_pkg::CMD_REF)) begin
            row_cnt_nxt = row_cnt_r + 12'h1;
            if (wake_cnt_r != 2'h2) begin
              wake_cnt_nxt = wake_cnt_r + 2'h1;
            end
          end else if (sirt_is(link.cmd, sirt_pkg::CMD_LMR)) begin
            cl_nxt = link.addr[sirt_pkg::MODE_CL_LSB +: 3];
          end else if (sirt_is(link.cmd, sirt_pkg::CMD_RD)) begin
            rd_cnt_nxt = cl_r - 3'h1;
            rd_idx_nxt = idx;
          end else if (sirt_is(link.cmd, sirt_pkg::CMD_WR)) begin
            wr_en = 1'b1;
          end
        end
      end
      SIRT_M_PD: begin
        // Inputs gated off: only clock enable is watched
        if (link.cke) begin
          st_nxt = SIRT_M_RUN;
        end
      end
      SIRT_M_SR: begin
        // Internal timer walks the row counter with no outside help
        if (sr_tmr_r == 16'(sirt_pkg::REF_CYC - 1)) begin
          sr_tmr_nxt  = 16'h0;
          row_cnt_nxt = row_cnt_r + 12'h1;
        end else begin
          sr_tmr_nxt = sr_tmr_r + 16'h1;
        end
        if (link.cke) begin
          st_nxt = SIRT_M_RUN;
        end
      end
      default: st_nxt = SIRT_M_RUN;
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r        <= SIRT_M_RUN;
      cke_prev_r  <= 1'b0;
      wake_cnt_r  <= 2'h0;
      bank_open_r <= 4'h0;
      cl_r        <= sirt_pkg::CAS_LAT_RST;
      row_cnt_r   <= 12'h0;
      sr_tmr_r    <= 16'h0;
      rd_cnt_r    <= 3'h0;
      rd_idx_r    <= 4'h0;
      dout_r      <= 32'h0;
      oe_n_r      <= 1'b1;
    end else if (ce) begin
      st_r        <= st_nxt;
      cke_prev_r  <= link.cke;
      wake_cnt_r  <= wake_cnt_nxt;
      bank_open_r <= bank_open_nxt;
      cl_r        <= cl_nxt;
      row_cnt_r   <= row_cnt_nxt;
      sr_tmr_r    <= sr_tmr_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      rd_idx_r    <= rd_idx_nxt;
      dout_r      <= dout_nxt;
      oe_n_r      <= oe_n_nxt;
    end
  end

  // Array has no reset: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      mem_r[idx] <= link.dq;
    end
  end

  assign link.dq_o_mem    = dout_r;
  assign link.dq_oe_n_mem = oe_n_r;
  assign init_done        = (wake_cnt_r == 2'h2);
  assign in_self_refresh  = (st_r == SIRT_M_SR);
  assign in_power_down    = (st_r == SIRT_M_PD);
  assign refresh_row      = row_cnt_r;

endmodule : sirt_mem

`default_nettype wire

// [sirt_ctl.sv]
/*
  Controller end: power-up sequence, periodic refresh with wake-up repeat,
  closed-page single-word reads and writes, power-down and self refresh.
  Assumes user requests are synchronous to mclk and the link clock is mclk.
*/
`default_nettype none
module sirt_ctl #(
  parameter int PWRUP_CYC = sirt_pkg::PWRUP_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  sirt_link_if.ctl                         link,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic [1:0]                  req_bank,
  input  wire logic [11:0]                 req_row,
  input  wire logic [8:0]                  req_col,
  input  wire logic [31:0]                 req_wdata,
  output logic                             rd_valid,
  output logic [31:0]                      rd_data,
  input  wire logic                        pd_req,
  input  wire logic                        sr_req,
  output logic                             init_done
);
  typedef enum logic [3:0] {
    SIRT_PWRUP, SIRT_IPRE, SIRT_IMRS, SIRT_REF, SIRT_IDLE, SIRT_ACT,
    SIRT_RD, SIRT_WR, SIRT_PRE, SIRT_PD, SIRT_SR, SIRT_SRX
  } sirt_state_t;
  localparam int W = sirt_pkg::WAIT_W;
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sirt_state_t                  st_r, st_nxt;
  logic [W-1:0]                 wait_r, wait_nxt;
  logic [15:0]                  ref_cnt_r, ref_cnt_nxt;
  logic [1:0]                   ref_left_r, ref_left_nxt;
  logic                         init_r, init_nxt;
  logic                         cke_r, cke_nxt;
  logic [3:0]                   cmd_r, cmd_nxt;
  logic [1:0]                   ba_r, ba_nxt;
  logic [11:0]                  addr_r, addr_nxt;
  logic [31:0]                  wd_r, wd_nxt;
  logic                         oe_n_r, oe_n_nxt;
  logic [31:0]                  rdat_r, rdat_nxt;
  logic                         rv_r, rv_nxt;
  logic                         wr_r, wr_nxt;
  logic [8:0]                   col_r, col_nxt;
  logic                         ref_due;
  logic                         ref_late;
  // Refresh due each row period; double the period means data at risk
  assign ref_due  = ref_cnt_r >= 16'(sirt_pkg::REF_CYC);
  assign ref_late = ref_cnt_r >= 16'(2 * sirt_pkg::REF_CYC);
  assign req_ready = (st_r == SIRT_IDLE) && !ref_due && !sr_req && !pd_req;
  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    wait_nxt     = (wait_r != '0) ? wait_r - W'(1) : wait_r;
    ref_cnt_nxt  = (ref_cnt_r != 16'hffff) ? ref_cnt_r + 16'h1 : ref_cnt_r;
    ref_left_nxt = ref_left_r;
    init_nxt     = init_r;
    cke_nxt      = 1'b1;
    cmd_nxt      = sirt_pkg::CMD_NOP;
    ba_nxt       = ba_r;
    addr_nxt     = addr_r;
    wd_nxt       = wd_r;
    oe_n_nxt     = 1'b1;
    rdat_nxt     = rdat_r;
    rv_nxt       = 1'b0;
    wr_nxt       = wr_r;
    col_nxt      = col_r;
    case (st_r)
      SIRT_PWRUP: begin
        // Pause ends with precharge-all so every bank starts idle
        if (wait_r == '0) begin
          cmd_nxt  = sirt_pkg::CMD_PRE;
          addr_nxt = 12'h1 << sirt_pkg::A_ALLBANK;
          st_nxt   = SIRT_IPRE;
          wait_nxt = W'(sirt_pkg::TRP_CYC - 1);
        end
      end
      SIRT_IPRE: begin
        // Mode load ahead of the wake-up refreshes
        if (wait_r == '0) begin
          cmd_nxt  = sirt_pkg::CMD_LMR;
          addr_nxt = sirt_pkg::MODE_VAL;
          st_nxt   = SIRT_IMRS;
          wait_nxt = W'(sirt_pkg::TMRD_CYC - 1);
        end
      end
      SIRT_IMRS: begin
        if (wait_r == '0) begin
          cmd_nxt      = sirt_pkg::CMD_REF;
          ref_left_nxt = 2'h1;
          ref_cnt_nxt  = 16'h0;
          st_nxt       = SIRT_REF;
          wait_nxt     = W'(sirt_pkg::TRFC_CYC - 1);
        end
      end
      SIRT_REF: begin
        if (wait_r == '0) begin
          if (ref_left_r != 2'h0) begin
            cmd_nxt      = sirt_pkg::CMD_REF;
            ref_left_nxt = ref_left_r - 2'h1;
            wait_nxt     = W'(sirt_pkg::TRFC_CYC - 1);
          end else begin
            init_nxt = 1'b1;
            st_nxt   = SIRT_IDLE;
          end
        end
      end
      SIRT_IDLE: begin
        // All banks are closed here, so low-power entry needs no precharge
        if (ref_due) begin
          cmd_nxt      = sirt_pkg::CMD_REF;
          ref_left_nxt = ref_late ? 2'h1 : 2'h0;
          ref_cnt_nxt  = 16'h0;
          st_nxt       = SIRT_REF;
          wait_nxt     = W'(sirt_pkg::TRFC_CYC - 1);
        end else if (sr_req) begin
          cmd_nxt = sirt_pkg::CMD_REF;
          cke_nxt = 1'b0;
          st_nxt  = SIRT_SR;
        end else if (pd_req) begin
          cke_nxt = 1'b0;
          st_nxt  = SIRT_PD;
        end else if (req_valid) begin
          cmd_nxt    = sirt_pkg::CMD_ACT;
          ba_nxt     = req_bank;
          addr_nxt   = req_row;
          wr_nxt     = req_write;
          col_nxt    = req_col;
          wd_nxt     = req_wdata;
          st_nxt     = SIRT_ACT;
          wait_nxt   = W'(sirt_pkg::TRCD_CYC - 1);
        end
      end
      SIRT_ACT: begin
        if (wait_r == '0) begin
          addr_nxt = {3'h0, col_r};
          if (wr_r) begin
            cmd_nxt  = sirt_pkg::CMD_WR;
            oe_n_nxt = 1'b0;
            st_nxt   = SIRT_WR;
            wait_nxt = W'(sirt_pkg::TWR_CYC);
          end else begin
            cmd_nxt  = sirt_pkg::CMD_RD;
            st_nxt   = SIRT_RD;
            wait_nxt = W'(sirt_pkg::CAS_LAT);
          end
        end
      end
      SIRT_RD: begin
        if (wait_r == '0) begin
          rdat_nxt = link.dq;
          rv_nxt   = 1'b1;
          cmd_nxt  = sirt_pkg::CMD_PRE;
          st_nxt   = SIRT_PRE;
          wait_nxt = W'(sirt_pkg::TRP_CYC - 1);
        end
      end
      SIRT_WR: begin
        // Recovery counted from the data cycle before the precharge
        if (wait_r == W'(1)) begin
          cmd_nxt  = sirt_pkg::CMD_PRE;
          st_nxt   = SIRT_PRE;
          wait_nxt = W'(sirt_pkg::TRP_CYC - 1);
        end
      end
      SIRT_PRE: begin
        if (wait_r == '0) begin
          st_nxt = SIRT_IDLE;
        end
      end
      SIRT_PD: begin
        // Leave power-down in time to keep the row period
        if (!pd_req || ref_due) begin
          st_nxt = SIRT_IDLE;
        end else begin
          cke_nxt = 1'b0;
        end
      end
      SIRT_SR: begin
        ref_cnt_nxt = 16'h0;
        if (!sr_req) begin
          st_nxt   = SIRT_SRX;
          wait_nxt = W'(sirt_pkg::SELF_REFRESH_EXIT_TIME_CYC - 1);
        end else begin
          cke_nxt = 1'b0;
        end
      end
      SIRT_SRX: begin
        // Free-running mclk gives many edges during the exit wait
        if (wait_r == '0) begin
          st_nxt = SIRT_IDLE;
        end
      end
      default: st_nxt = SIRT_PWRUP;
    endcase
  end
  // ------------------------------------------------------------------
  // Registers; ce low freezes the link, single clock keeps rate fixed
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= SIRT_PWRUP;
      wait_r     <= W'(PWRUP_CYC);
      ref_cnt_r  <= 16'h0;
      ref_left_r <= 2'h0;
      init_r     <= 1'b0;
      cke_r      <= 1'b1;
      cmd_r      <= sirt_pkg::CMD_NOP;
      ba_r       <= 2'h0;
      addr_r     <= 12'h000;
      wd_r       <= 32'h0;
      oe_n_r     <= 1'b1;
      rdat_r     <= 32'h0;
      rv_r       <= 1'b0;
      wr_r       <= 1'b0;
      col_r      <= 9'h000;
    end else if (ce) begin
      st_r       <= st_nxt;
      wait_r     <= wait_nxt;
      ref_cnt_r  <= ref_cnt_nxt;
      ref_left_r <= ref_left_nxt;
      init_r     <= init_nxt;
      cke_r      <= cke_nxt;
      cmd_r      <= cmd_nxt;
      ba_r       <= ba_nxt;
      addr_r     <= addr_nxt;
      wd_r       <= wd_nxt;
      oe_n_r     <= oe_n_nxt;
      rdat_r     <= rdat_nxt;
      rv_r       <= rv_nxt;
      wr_r       <= wr_nxt;
      col_r      <= col_nxt;
    end
  end
  assign link.cke         = cke_r;
  assign link.cmd         = cmd_r;
  assign link.ba          = ba_r;
  assign link.addr        = addr_r;
  assign link.dq_o_ctl    = wd_r;
  assign link.dq_oe_n_ctl = oe_n_r;
  assign rd_valid         = rv_r;
  assign rd_data          = rdat_r;
  assign init_done        = init_r;
endmodule : sirt_ctl
`default_nettype wire

// [sirt_assertions.sv]
/* Link checker: timing relations between the two ends of the memory link.
   Assumes ce drops only while the link rests in self refresh, so every
   edge that these cycle counts span is a live edge. */
`default_nettype none
module sirt_assertions (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       cke,
  input wire logic [3:0] cmd,
  input wire logic       dq_oe_n_ctl,
  input wire logic       dq_oe_n_mem
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------
  // Link relations
  // --------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_mode_ref_gap: assert property (cmd == sirt_pkg::CMD_LMR |=>
    cmd == sirt_pkg::CMD_NOP ##1 cmd == sirt_pkg::CMD_REF) else $error("mode to refresh gap");
  chk_refresh_gap: assert property (cmd == sirt_pkg::CMD_REF && cke |=>
    cmd == sirt_pkg::CMD_NOP [*8]) else $error("refresh gap short");
  chk_pre_gap: assert property (cmd == sirt_pkg::CMD_PRE |=>
    cmd == sirt_pkg::CMD_NOP [*2]) else $error("precharge gap short");
  chk_pre_hiz: assert property (cmd == sirt_pkg::CMD_PRE |=>
    dq_oe_n_mem [*3]) else $error("memory drives after precharge");
  chk_wr_recovery: assert property (cmd == sirt_pkg::CMD_WR |=>
    cmd == sirt_pkg::CMD_NOP ##1 cmd == sirt_pkg::CMD_PRE) else $error("write recovery");
  chk_wr_data: assert property (cmd == sirt_pkg::CMD_WR |->
    !dq_oe_n_ctl ##1 dq_oe_n_ctl) else $error("write data slot");
  chk_act_delay: assert property (cmd == sirt_pkg::CMD_ACT |=> cmd == sirt_pkg::CMD_NOP [*2]
    ##1 (cmd == sirt_pkg::CMD_RD || cmd == sirt_pkg::CMD_WR)) else $error("act to access");
  chk_rd_latency: assert property (cmd == sirt_pkg::CMD_RD |->
    ##2 dq_oe_n_mem ##1 !dq_oe_n_mem) else $error("read latency");
  chk_lowpower_quiet: assert property (!cke |->
    cmd == sirt_pkg::CMD_NOP || cmd == sirt_pkg::CMD_REF) else $error("command in low power");
  // Main scenarios reached
  cover property (cmd == sirt_pkg::CMD_RD ##3 !dq_oe_n_mem);
  cover property (cmd == sirt_pkg::CMD_WR);
  cover property (!cke ##1 !cke);
endmodule : sirt_assertions
`default_nettype wire

// [testbench.sv]
/* Testbench: both ends joined by the link, user side driven by tasks.
   Assumes a power-up pause shortened to 20 clocks; ce drops only in self refresh. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rstn, ce, req_valid, req_ready, req_write, rd_valid, pd_req, sr_req;
  logic        ctl_done, mem_done, in_sr, in_pd;
  logic [1:0]  req_bank;
  logic [8:0]  req_col;
  logic [11:0] req_row, refresh_row, row_seen;
  logic [31:0] req_wdata, rd_data;
  int          fail_count, n_compared;
  sirt_link_if u_sirt_link_if ();
  sirt_ctl #(.PWRUP_CYC(20)) u_sirt_ctl (.mclk(mclk), .rstn(rstn), .ce(ce),
    .link(u_sirt_link_if), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .pd_req(pd_req),
    .sr_req(sr_req), .init_done(ctl_done));
  sirt_mem u_sirt_mem (.mclk(mclk), .rstn(rstn), .ce(ce), .link(u_sirt_link_if),
    .init_done(mem_done), .in_self_refresh(in_sr), .in_power_down(in_pd),
    .refresh_row(refresh_row));
  sirt_assertions u_sirt_assertions (.mclk(mclk), .rstn(rstn), .cke(u_sirt_link_if.cke),
    .cmd(u_sirt_link_if.cmd), .dq_oe_n_ctl(u_sirt_link_if.dq_oe_n_ctl),
    .dq_oe_n_mem(u_sirt_link_if.dq_oe_n_mem));
  // -----
  // Tasks
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held until the edge that sees ready; an extra edge avoids double drive
  task automatic request(input logic w, input logic [1:0] b, input logic [8:0] c,
                         input logic [31:0] d);
    int n;
    n = 0;
    req_write <= w;
    req_bank <= b;
    req_col <= c;
    req_row <= {3'h5, c};
    req_wdata <= d;
    req_valid <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 500);
    chk({31'h0, req_ready}, 32'h1);
    @(posedge mclk);
    req_valid <= 1'b0;
    @(posedge mclk);
  endtask : request
  task automatic rd(input logic [1:0] b, input logic [8:0] c, input logic [31:0] e);
    int n;
    n = 0;
    request(1'b0, b, c, 32'h0);
    do begin
      @(negedge mclk);
      n++;
    end while (rd_valid !== 1'b1 && n < 20);
    chk({31'h0, rd_valid}, 32'h1);
    chk(rd_data, e);
    @(posedge mclk);
  endtask : rd
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // --------
  // Stimulus
  // --------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole run is about 6500 clocks; several times that means a hang
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  initial begin
    {rstn, req_valid, req_write, pd_req, sr_req} = 5'h0;
    ce = 1'b1;
    {req_bank, req_col, req_row, req_wdata} = '0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (15) @(posedge mclk);
    chk({31'h0, ctl_done}, 32'h0);
    repeat (45) @(posedge mclk);
    chk({30'h0, ctl_done, mem_done}, 32'h3);
    for (int i = 0; i < 4; i++) request(1'b1, 2'(i), 9'(5 * i), 32'ha5a5_0000 + i);
    for (int i = 0; i < 4; i++) rd(2'(i), 9'(5 * i), 32'ha5a5_0000 + i);
    pd_req <= 1'b1;
    repeat (20) @(posedge mclk);
    chk({30'h0, in_pd, u_sirt_link_if.cke}, 32'h2);
    pd_req <= 1'b0;
    sr_req <= 1'b1;
    repeat (20) @(posedge mclk);
    row_seen = refresh_row;
    // Frozen span covers an internal refresh tick, so a leak would show
    ce <= 1'b0;
    repeat (1980) @(posedge mclk);
    chk(32'(refresh_row - row_seen), 32'h0);
    ce <= 1'b1;
    repeat (3980) @(posedge mclk);
    chk({31'h0, in_sr}, 32'h1);
    chk(32'(refresh_row - row_seen), 32'h2);
    sr_req <= 1'b0;
    for (int i = 0; i < 4; i++) rd(2'(i), 9'(5 * i), 32'ha5a5_0000 + i);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
